// File: core/port_io_pkg.sv
package port_io_pkg;

	// Register byte addresses on the APB slave
	localparam logic [7:0] OFS_C_PINS  = 8'h00;
	localparam logic [7:0] OFS_C_LATCH = 8'h04;
	localparam logic [7:0] OFS_C_DIR   = 8'h08;
	localparam logic [7:0] OFS_D_PINS  = 8'h0C;
	localparam logic [7:0] OFS_D_LATCH = 8'h10;
	localparam logic [7:0] OFS_D_DIR   = 8'h14;
	localparam logic [7:0] OFS_E_DIR   = 8'h18;
	localparam logic [7:0] OFS_CONFIG  = 8'h1C;

	// Reset values
	localparam logic [7:0] RST_DIR      = 8'hFF;
	localparam logic [7:0] RST_LATCH    = 8'h00;
	localparam logic [7:0] RST_E_DIR    = 8'h07;
	localparam logic       RST_CAP2_SEL = 1'b1;

	// Field and pin positions
	localparam int SLAVE_MODE_BIT = 4;
	localparam int CAP2_SEL_BIT   = 0;
	localparam int C_CAP2_BIT     = 1;
	localparam int C_SDA_BIT      = 4;
	localparam int C_SDO_BIT      = 5;
	localparam int C_CLK_BIT      = 6;
	localparam int C_DATA_BIT     = 7;
	localparam int D_PWM_BASE     = 5;
	localparam int PWM_CHANNELS   = 3;

	// Peripheral functions offered to the pins
	typedef struct packed {
		logic       i2c_en;
		logic       sda_out;
		logic       spi_en;
		logic       spi_data_out;
		logic       tx_en;
		logic       tx_out;
		logic       sync_en;
		logic       sync_clk_out;
		logic       sync_data_out;
		logic       capture2_drive;
		logic       capture2_out;
		logic       pwm_multi;
		logic [2:0] pwm_en;
		logic [2:0] pwm_out;
		logic       psp_read;
	} periph_in_type;

	// Pin levels handed back to the peripherals
	typedef struct packed {
		logic       sda_in;
		logic       spi_data_in;
		logic       sync_clk_in;
		logic       rx_in;
		logic       sync_data_in;
		logic       capture2_in;
		logic [7:0] psp_write_data;
	} periph_out_type;

	// Whole state of the port block
	typedef struct packed {
		logic [7:0]  latch_c;
		logic [7:0]  dir_c;
		logic [7:0]  latch_d;
		logic [7:0]  dir_d;
		logic [7:0]  dir_e;
		logic        cap2_sel;
		logic [7:0]  pin_c;
		logic [7:0]  pin_d;
		logic [7:0]  alt_pin;
		logic [7:0]  c_o;
		logic [7:0]  c_oe;
		logic [7:0]  d_o;
		logic [7:0]  d_oe;
		logic        alt_o;
		logic        alt_oe;
		logic [31:0] rdata;
		logic        err;
	} state_type;

endpackage

// File: core/dual_port_io.sv
// Summary of operation
// - Port D direction bit one makes that pin an input, driver off.
// - Port D direction bit zero drives the latch bit onto the pin.
// - Port D latch has its own address and reads back latch, not pins.
// - Eight port D pins, each with its own direction bit.
// - After reset all port D direction bits are set: all inputs.
// - Slave mode bit 4 of port E direction makes port D a slave port.
// - Dual or quad PWM output disables the slave port on port D.
// - Port D pins 5 to 7 carry PWM outputs B, C and D.
// - Port C bit 4: I2C data drives when direction 0, input when 1.
// - Port C bit 4: SPI data in taken from pin while direction is 1.
// - Port C bit 5: SPI data out drives pin when direction is 0.
// - Port C bit 6: serial clock drives at direction 0, input at 1.
// - Port C bit 7: receive data taken from pin while direction is 1.
// - Port C bit 7: sync data drives at direction 0, input at 1.
// - Only the slave port sets pin direction regardless of direction bit.
// - Select bit set routes capture 2 to port C pin 1, else alt pin.
// - Port C pins map bit for bit; the latch reads and writes back.
// - Direction registers read back stored bits despite overrides.
`timescale 1ns/100ps
`default_nettype none

module dual_port_io (
	// Clock and reset
	input  wire logic                     CLK_I,
	input  wire logic                     RST_I,
	// APB slave
	input  wire logic                     PSEL_I,
	input  wire logic                     PENABLE_I,
	input  wire logic                     PWRITE_I,
	input  wire logic [7:0]               PADDR_I,
	input  wire logic [31:0]              PWDATA_I,
	input  wire logic [3:0]               PSTRB_I,
	output logic      [31:0]              PRDATA_O,
	output logic                          PREADY_O,
	output logic                          PSLVERR_O,
	// Port C pins
	input  wire logic [7:0]               PORT_C_I,
	output logic      [7:0]               PORT_C_O,
	output logic      [7:0]               PORT_C_OE_O,
	// Port D pins
	input  wire logic [7:0]               PORT_D_I,
	output logic      [7:0]               PORT_D_O,
	output logic      [7:0]               PORT_D_OE_O,
	// Alternate capture 2 pin
	input  wire logic                     ALT_CAPTURE2_I,
	output logic                          ALT_CAPTURE2_O,
	output logic                          ALT_CAPTURE2_OE_O,
	// Peripheral side
	input  wire port_io_pkg::periph_in_type  PERIPH_I,
	output port_io_pkg::periph_out_type      PERIPH_O
);
	import port_io_pkg::*;

	state_type st;
	state_type next_st;
	logic      setup;
	logic      wr;
	logic      psp_on;

	// Address match, shared by the write and the read decode
	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = hit(addr, OFS_C_PINS) || hit(addr, OFS_C_LATCH) ||
			hit(addr, OFS_C_DIR) || hit(addr, OFS_D_PINS) ||
			hit(addr, OFS_D_LATCH) || hit(addr, OFS_D_DIR) ||
			hit(addr, OFS_E_DIR) || hit(addr, OFS_CONFIG);
	endfunction

	// Bus phases; the access phase never waits
	assign setup = PSEL_I && !PENABLE_I;
	assign wr    = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];

	// Slave port runs only while PWM uses a single output
	assign psp_on = st.dir_e[SLAVE_MODE_BIT] && !PERIPH_I.pwm_multi;

	// Next state: registers, pin sampling and pin drive
	always_comb begin
		next_st = st;
		next_st.pin_c   = PORT_C_I;
		next_st.pin_d   = PORT_D_I;
		next_st.alt_pin = {7'h00, ALT_CAPTURE2_I};

		// Register writes, low byte only
		if (wr && mapped(PADDR_I) && hit(PADDR_I, OFS_C_PINS)) begin
			next_st.latch_c = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_C_LATCH)) begin
			next_st.latch_c = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_C_DIR)) begin
			next_st.dir_c = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_D_PINS)) begin
			next_st.latch_d = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_D_LATCH)) begin
			next_st.latch_d = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_D_DIR)) begin
			next_st.dir_d = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_E_DIR)) begin
			next_st.dir_e = PWDATA_I[7:0];
		end
		if (wr && hit(PADDR_I, OFS_CONFIG)) begin
			next_st.cap2_sel = PWDATA_I[CAP2_SEL_BIT];
		end

		// Read data is fetched in the setup cycle so it leaves a flop
		if (setup) begin
			next_st.err   = !mapped(PADDR_I);
			next_st.rdata = 32'h0000_0000;
			unique case (1'b1)
				hit(PADDR_I, OFS_C_PINS):  next_st.rdata[7:0] = st.pin_c;
				hit(PADDR_I, OFS_C_LATCH): next_st.rdata[7:0] = st.latch_c;
				hit(PADDR_I, OFS_C_DIR):   next_st.rdata[7:0] = st.dir_c;
				hit(PADDR_I, OFS_D_PINS):  next_st.rdata[7:0] = st.pin_d;
				hit(PADDR_I, OFS_D_LATCH): next_st.rdata[7:0] = st.latch_d;
				hit(PADDR_I, OFS_D_DIR):   next_st.rdata[7:0] = st.dir_d;
				hit(PADDR_I, OFS_E_DIR):   next_st.rdata[7:0] = st.dir_e;
				hit(PADDR_I, OFS_CONFIG):  next_st.rdata[0]   = st.cap2_sel;
				default:                   next_st.rdata      = 32'h0000_0000;
			endcase
		end

		// Port C: latch by default, peripherals take over per pin
		next_st.c_o  = st.latch_c;
		next_st.c_oe = ~st.dir_c;
		if (PERIPH_I.i2c_en && !st.dir_c[C_SDA_BIT]) begin
			next_st.c_o[C_SDA_BIT] = PERIPH_I.sda_out;
		end
		if (PERIPH_I.spi_en && !st.dir_c[C_SDO_BIT]) begin
			next_st.c_o[C_SDO_BIT] = PERIPH_I.spi_data_out;
		end
		// Sync clock beats transmit; both need the direction bit cleared
		if (PERIPH_I.sync_en && !st.dir_c[C_CLK_BIT]) begin
			next_st.c_o[C_CLK_BIT] = PERIPH_I.sync_clk_out;
		end else if (PERIPH_I.tx_en && !st.dir_c[C_CLK_BIT]) begin
			next_st.c_o[C_CLK_BIT] = PERIPH_I.tx_out;
		end
		if (PERIPH_I.sync_en && !st.dir_c[C_DATA_BIT]) begin
			next_st.c_o[C_DATA_BIT] = PERIPH_I.sync_data_out;
		end
		if (st.cap2_sel && PERIPH_I.capture2_drive &&
			!st.dir_c[C_CAP2_BIT]) begin
			next_st.c_o[C_CAP2_BIT] = PERIPH_I.capture2_out;
		end
		// Alternate pin has no direction bit here: the peripheral decides
		next_st.alt_o  = PERIPH_I.capture2_out;
		next_st.alt_oe = !st.cap2_sel && PERIPH_I.capture2_drive;

		// Port D: per-pin direction from its own bit
		next_st.d_o  = st.latch_d;
		next_st.d_oe = ~st.dir_d;
		if (psp_on) begin
			// Slave port ignores direction bits and drives on a read cycle
			next_st.d_oe = {8{PERIPH_I.psp_read}};
		end
		// PWM outputs win over port and slave port data
		for (int k = 0; k < PWM_CHANNELS; k++) begin
			if (PERIPH_I.pwm_en[k] && !st.dir_d[D_PWM_BASE + k]) begin
				next_st.d_o[D_PWM_BASE + k]  = PERIPH_I.pwm_out[k];
				next_st.d_oe[D_PWM_BASE + k] = 1'b1;
			end
		end
	end

	// State register; all pins start as inputs
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st          <= '0;
			st.latch_c  <= RST_LATCH;
			st.dir_c    <= RST_DIR;
			st.latch_d  <= RST_LATCH;
			st.dir_d    <= RST_DIR;
			st.dir_e    <= RST_E_DIR;
			st.cap2_sel <= RST_CAP2_SEL;
		end else begin
			st <= next_st;
		end
	end

	// Bus answers
	assign PRDATA_O  = st.rdata;
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && st.err;

	// Pin drivers, one cycle behind the registers
	assign PORT_C_O          = st.c_o;
	assign PORT_C_OE_O       = st.c_oe;
	assign PORT_D_O          = st.d_o;
	assign PORT_D_OE_O       = st.d_oe;
	assign ALT_CAPTURE2_O    = st.alt_o;
	assign ALT_CAPTURE2_OE_O = st.alt_oe;

	// Inputs to peripherals come from sampled pins; port C serial inputs gated by direction
	assign PERIPH_O.sda_in         = st.dir_c[C_SDA_BIT] & st.pin_c[C_SDA_BIT];
	assign PERIPH_O.spi_data_in    = st.dir_c[C_SDA_BIT] & st.pin_c[C_SDA_BIT];
	assign PERIPH_O.sync_clk_in    = st.dir_c[C_CLK_BIT] & st.pin_c[C_CLK_BIT];
	assign PERIPH_O.rx_in          = st.dir_c[C_DATA_BIT] & st.pin_c[C_DATA_BIT];
	assign PERIPH_O.sync_data_in   = st.dir_c[C_DATA_BIT] & st.pin_c[C_DATA_BIT];
	assign PERIPH_O.capture2_in    = st.cap2_sel ? st.pin_c[C_CAP2_BIT]
		: st.alt_pin[0];
	assign PERIPH_O.psp_write_data = psp_on ? st.pin_d : 8'h00;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_latch_d_write;
		PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] &&
		PADDR_I == OFS_D_LATCH;
	endsequence

	sequence s_dir_read_setup;
		PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == OFS_C_DIR;
	endsequence

	a_dir_input_off: assert property (
		(st.dir_d[0] && !psp_on) |=> !PORT_D_OE_O[0])
		else $error("input pin still driven");
	a_dir_output_latch: assert property (
		(!st.dir_d[1] && !psp_on) |=>
		PORT_D_OE_O[1] && PORT_D_O[1] == $past(st.latch_d[1]))
		else $error("output pin does not show latch");
	// Write, one idle cycle, then a read setup of the same latch
	a_latch_readback: assert property (
		s_latch_d_write ##2 (PSEL_I && !PENABLE_I && !PWRITE_I &&
		PADDR_I == OFS_D_LATCH) |=> PRDATA_O[7:0] == $past(PWDATA_I[7:0], 3))
		else $error("latch readback differs from write");
	a_dir_readback: assert property (
		s_dir_read_setup |=> PRDATA_O[7:0] == $past(st.dir_c))
		else $error("direction read wrong");
	a_pwm_blocks_slave: assert property (
		(PERIPH_I.pwm_multi && st.dir_d[0]) |=> !PORT_D_OE_O[0])
		else $error("slave port active with multi PWM");
	a_i2c_data_drive: assert property (
		(PERIPH_I.i2c_en && !st.dir_c[C_SDA_BIT]) |=>
		PORT_C_O[C_SDA_BIT] == $past(PERIPH_I.sda_out))
		else $error("I2C data not on pin");
	a_spi_out_drive: assert property (
		(PERIPH_I.spi_en && !st.dir_c[C_SDO_BIT]) |=>
		PORT_C_OE_O[C_SDO_BIT] &&
		PORT_C_O[C_SDO_BIT] == $past(PERIPH_I.spi_data_out))
		else $error("SPI data not on pin");
	a_sync_clk_drive: assert property (
		(PERIPH_I.sync_en && !st.dir_c[C_CLK_BIT]) |=>
		PORT_C_O[C_CLK_BIT] == $past(PERIPH_I.sync_clk_out))
		else $error("sync clock not on pin");
	a_capture_alt_route: assert property (
		(!st.cap2_sel && PERIPH_I.capture2_drive) |=> ALT_CAPTURE2_OE_O)
		else $error("capture 2 not on alternate pin");
	a_pins_write_latch: assert property (
		(wr && PADDR_I == OFS_C_PINS) |=> st.latch_c == $past(PWDATA_I[7:0]))
		else $error("pin register write missed latch");

	// Bus steps shared by the checks below
	sequence s_d_pins_write;
		PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] &&
		PADDR_I == OFS_D_PINS;
	endsequence

	sequence s_d_dir_write;
		PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] &&
		PADDR_I == OFS_D_DIR;
	endsequence

	sequence s_c_pins_read_setup;
		PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == OFS_C_PINS;
	endsequence

	sequence s_c_latch_read_setup;
		PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == OFS_C_LATCH;
	endsequence

	// Port D pin register write lands in the latch, not the pins
	a_d_pins_write: assert property (
		s_d_pins_write |=> st.latch_d == $past(PWDATA_I[7:0]))
		else $error("port D pin write missed latch");

	// Each direction bit is stored as written, bit for bit
	a_d_dir_write: assert property (
		s_d_dir_write |=> st.dir_d == $past(PWDATA_I[7:0]))
		else $error("port D direction write lost");

	// Leaving reset, no port D pin may be an output
	a_reset_inputs: assert property (
		$fell(RST_I) |-> st.dir_d == RST_DIR && PORT_D_OE_O == 8'h00)
		else $error("port D not all inputs after reset");

	// Pin register read returns the level sampled one edge before the setup edge
	a_c_pins_read: assert property (
		s_c_pins_read_setup |=> PRDATA_O[7:0] == $past(st.pin_c))
		else $error("port C pin read wrong");

	// Latch read returns the latch, whatever the pins show
	a_c_latch_read: assert property (
		s_c_latch_read_setup |=> PRDATA_O[7:0] == $past(st.latch_c))
		else $error("port C latch read wrong");

	// Outside slave mode the slave port sees nothing of the pins
	a_slave_data_idle: assert property (
		!psp_on |-> PERIPH_O.psp_write_data == 8'h00)
		else $error("slave data leaks outside slave mode");

	// Slave read cycle drives the bus, direction bits ignored
	a_slave_drive: assert property (
		(psp_on && PERIPH_I.psp_read) |=> PORT_D_OE_O[0])
		else $error("slave port read not driven");

	// PWM channel B owns its pin once its direction bit is clear
	a_pwm_wins: assert property (
		(PERIPH_I.pwm_en[0] && !st.dir_d[D_PWM_BASE]) |=>
		PORT_D_OE_O[D_PWM_BASE] &&
		PORT_D_O[D_PWM_BASE] == $past(PERIPH_I.pwm_out[0]))
		else $error("PWM output not on pin");

	// An output pin must not feed its own drive back as I2C data
	a_sda_in_gate: assert property (
		!st.dir_c[C_SDA_BIT] |-> !PERIPH_O.sda_in)
		else $error("I2C data input seen on output pin");

	// SPI input is blind while the pin is an output
	a_spi_in_gate: assert property (
		!st.dir_c[C_SDA_BIT] |-> !PERIPH_O.spi_data_in)
		else $error("SPI data input seen on output pin");

	// Transmit reaches the pin when the sync clock is not using it
	a_tx_drive: assert property (
		(PERIPH_I.tx_en && !PERIPH_I.sync_en && !st.dir_c[C_CLK_BIT]) |=>
		PORT_C_OE_O[C_CLK_BIT] &&
		PORT_C_O[C_CLK_BIT] == $past(PERIPH_I.tx_out))
		else $error("transmit data not on pin");

	// Clock input follows the pin one sample late
	a_clk_in_pin: assert property (
		(!$past(RST_I) && st.dir_c[C_CLK_BIT]) |->
		PERIPH_O.sync_clk_in == $past(PORT_C_I[C_CLK_BIT]))
		else $error("sync clock input not from pin");

	// Receive input follows the pin one sample late
	a_rx_from_pin: assert property (
		(!$past(RST_I) && st.dir_c[C_DATA_BIT]) |->
		PERIPH_O.rx_in == $past(PORT_C_I[C_DATA_BIT]))
		else $error("receive input not from pin");

	// Sync data drives as output and is blind to its own drive
	a_sync_data_drive: assert property (
		(PERIPH_I.sync_en && !st.dir_c[C_DATA_BIT]) |=>
		PORT_C_OE_O[C_DATA_BIT] && !PERIPH_O.sync_data_in &&
		PORT_C_O[C_DATA_BIT] == $past(PERIPH_I.sync_data_out))
		else $error("sync data not on pin");

	// Default routing keeps the alternate pin released
	a_capture_default: assert property (
		st.cap2_sel |=> !ALT_CAPTURE2_OE_O)
		else $error("alternate pin driven in default routing");

	// Overrides on other pins leave the stored directions alone
	a_dir_kept: assert property (
		!(PSEL_I && PENABLE_I && PWRITE_I) |=> st.dir_c == $past(st.dir_c))
		else $error("direction changed without a write");

endmodule

`default_nettype wire

// File: tb/board_pins.sv
`timescale 1ns/100ps
`default_nettype none

module board_pins #(
	parameter int W = 8
) (
	// Device side of the pins
	input  wire logic [W-1:0] oe_i,
	input  wire logic [W-1:0] dev_i,
	// Level the board sets on a pin the device has released
	input  wire logic [W-1:0] ext_i,
	// Resolved wire level
	output logic      [W-1:0] level_o
);
	// A released driver never leaves its last value on the wire
	always_comb begin
		for (int i = 0; i < W; i++) begin
			level_o[i] = oe_i[i] ? dev_i[i] : ext_i[i];
		end
	end
endmodule

`default_nettype wire

// File: tb/test_dual_port_io.sv
`timescale 1ns/100ps
`default_nettype none

module test_dual_port_io;
	import port_io_pkg::*;
	logic           clk, rst, psel, penable, pwrite, pready, pslverr, serr;
	logic [7:0]     paddr, c_o, c_oe, c_lvl, c_ext, d_o, d_oe, d_lvl, d_ext;
	logic [31:0]    pwdata, prdata, rdat;
	logic [3:0]     pstrb;
	logic           alt_o, alt_oe, alt_lvl, alt_ext;
	periph_in_type  pi;
	periph_out_type po;
	int             err_count, n_checks, cyc;

	dual_port_io dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PORT_C_I(c_lvl),
		.PORT_C_O(c_o), .PORT_C_OE_O(c_oe), .PORT_D_I(d_lvl),
		.PORT_D_O(d_o), .PORT_D_OE_O(d_oe), .ALT_CAPTURE2_I(alt_lvl),
		.ALT_CAPTURE2_O(alt_o), .ALT_CAPTURE2_OE_O(alt_oe),
		.PERIPH_I(pi), .PERIPH_O(po));
	board_pins #(.W(8)) board_c (.oe_i(c_oe), .dev_i(c_o), .ext_i(c_ext),
		.level_o(c_lvl));
	board_pins #(.W(8)) board_d (.oe_i(d_oe), .dev_i(d_o), .ext_i(d_ext),
		.level_o(d_lvl));
	board_pins #(.W(1)) board_a (.oe_i(alt_oe), .dev_i(alt_o),
		.ext_i(alt_ext), .level_o(alt_lvl));

	// 250 MHz system clock
	initial clk = 1'b0;
	always #2 clk = ~clk;

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			finish_test;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, {24'h0, exp});
	endtask

	// Register to pin flop takes one edge; margin for pin sampling
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_reset;
		chk({16'h0, c_oe, d_oe}, 32'h0);
		rd(OFS_D_DIR, RST_DIR);
		rd(OFS_C_DIR, RST_DIR);
		rd(OFS_D_LATCH, RST_LATCH);
		rd(OFS_E_DIR, RST_E_DIR);
		rd(OFS_CONFIG, 8'h01);
	endtask

	task automatic t_port_d;
		wr(OFS_D_LATCH, 8'hA5);
		rd(OFS_D_LATCH, 8'hA5);
		wr(OFS_D_DIR, 8'h0F);
		settle;
		chk({16'h0, d_oe, d_o & d_oe}, 32'hF0A0);
		rd(OFS_D_PINS, 8'hAA);
		rd(OFS_D_LATCH, 8'hA5);
		wr(OFS_D_PINS, 8'h3C);
		rd(OFS_D_LATCH, 8'h3C);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_D_DIR, ~(8'h01 << i));
			settle;
			chk({24'h0, d_oe}, 32'h1 << i);
		end
		wr(OFS_D_DIR, 8'hFF);
	endtask

	task automatic t_refuse;
		apb(1'b1, 8'h20, 32'hFF);
		chk({31'h0, serr}, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk({serr, rdat[30:0]}, 32'h80000000);
	endtask

	task automatic t_port_c;
		wr(OFS_C_LATCH, 8'hF0);
		wr(OFS_C_DIR, 8'h0F);
		@(posedge clk);
		pi.i2c_en <= 1'b1;
		pi.spi_en <= 1'b1;
		pi.sync_en <= 1'b1;
		settle;
		chk({24'h0, c_oe[7:4], c_o[7:4]}, 32'hF0);
		pi.sync_en <= 1'b0;
		pi.tx_en <= 1'b1;
		settle;
		chk({31'h0, c_o[6]}, 32'h0);
		rd(OFS_C_DIR, 8'h0F);
		wr(OFS_C_DIR, 8'hFF);
		// Two pin patterns so no input can pass by sitting still
		c_ext <= 8'hB0;
		settle;
		chk({po.rx_in, po.sync_clk_in, po.spi_data_in, po.sda_in,
			po.sync_data_in}, 32'h17);
		rd(OFS_C_PINS, 8'hB0);
		c_ext <= 8'h40;
		settle;
		chk({po.rx_in, po.sync_clk_in, po.spi_data_in, po.sda_in,
			po.sync_data_in}, 32'h08);
		rd(OFS_C_LATCH, 8'hF0);
		pi <= '0;
	endtask

	task automatic t_slave;
		wr(OFS_D_LATCH, 8'h96);
		wr(OFS_E_DIR, 8'h17);
		@(posedge clk);
		pi.psp_read <= 1'b1;
		settle;
		chk({16'h0, d_oe, d_o}, 32'hFF96);
		pi.psp_read <= 1'b0;
		d_ext <= 8'h3C;
		settle;
		chk({24'h0, po.psp_write_data}, 32'h3C);
		pi.psp_read <= 1'b1;
		pi.pwm_multi <= 1'b1;
		settle;
		chk({24'h0, d_oe}, 32'h0);
		wr(OFS_D_DIR, 8'h1F);
		pi.pwm_en <= 3'h7;
		pi.pwm_out <= 3'h5;
		settle;
		chk({24'h0, d_oe[7:5], d_o[7:5]}, 32'h3D);
		pi <= '0;
		wr(OFS_E_DIR, RST_E_DIR);
		wr(OFS_D_DIR, 8'hFF);
	endtask

	task automatic t_cap2;
		wr(OFS_C_LATCH, 8'h00);
		wr(OFS_C_DIR, 8'hFD);
		pi.capture2_drive <= 1'b1;
		pi.capture2_out <= 1'b1;
		settle;
		chk({30'h0, c_o[1], alt_oe}, 32'h2);
		wr(OFS_CONFIG, 8'h00);
		settle;
		chk({29'h0, c_o[1], alt_oe, alt_o}, 32'h3);
		pi.capture2_drive <= 1'b0;
		alt_ext <= 1'b1;
		settle;
		chk({30'h0, alt_oe, po.capture2_in}, 32'h1);
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h1;
		pi = '0;
		c_ext = 8'h00;
		d_ext = 8'h5A;
		alt_ext = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_port_d;
		t_refuse;
		t_port_c;
		t_slave;
		t_cap2;
		finish_test;
	end
endmodule

`default_nettype wire
